/* rtl/pfl_consts.svh */
// Purpose: Register offsets, field positions, reset values and timing counts
//          for the line period and switching frequency block.
// Assumes: Clock mclk at 40 MHz.
// Notes:   Included by its bare name.
`ifndef PFL_CONSTS_SVH
`define PFL_CONSTS_SVH

`define PFL_ADDR_BUS_POWER_CMD 16'h0001
`define PFL_ADDR_POWER_SRC 16'h0002
`define PFL_ADDR_FREQ_SEL 16'hfe1b
`define PFL_ADDR_LEVEL_CFG 16'hfe25
`define PFL_ADDR_AVG_READ 16'hfe26
`define PFL_ADDR_PERIOD_FLOOR 16'hfe27
`define PFL_ADDR_PERIOD_CEIL 16'hfe28
`define PFL_ADDR_PERIOD_READ 16'hfe85

`define PFL_SRC_POL_BIT 1
`define PFL_SRC_CMD_EN_BIT 2
`define PFL_SRC_PIN_EN_BIT 3
`define PFL_CMD_ON_BIT 7

`define PFL_RST_BUS_POWER_CMD 8'h00
`define PFL_RST_POWER_SRC 8'h0a
`define PFL_RST_FREQ_SEL 8'h00
`define PFL_RST_LEVEL_CFG 8'h20
`define PFL_RST_PERIOD_FLOOR 8'h46
`define PFL_RST_PERIOD_CEIL 8'h6e

`define PFL_MCLK_PERIOD_NS 25
`define PFL_STARTUP_TIME_MS 40
`define PFL_PERIOD_LSB_US 100
`define PFL_PERIOD_LSB_CYCLES (`PFL_PERIOD_LSB_US * 1000 / `PFL_MCLK_PERIOD_NS)

`endif

/* rtl/pfl_pkg.sv */
// Purpose: Types of the line period and switching frequency block.
// Assumes: Nothing beyond the constants header.
// Notes:   All block state is one packed struct.
package pfl_pkg;

	typedef enum logic [1:0]
	{
		PFL_IDLE = 2'b00,
		PFL_ARM = 2'b01,
		PFL_MEAS = 2'b10
	} pfl_phase_t;

	typedef struct packed
	{
		logic [7:0] bus_cmd;
		logic [7:0] src_cfg;
		logic [7:0] freq_sel;
		logic [7:0] level_cfg;
		logic [7:0] floor_cfg;
		logic [7:0] ceil_cfg;
		logic [7:0] rdata;
		logic pin_s1;
		logic pin_s2;
		logic conv_on;
		pfl_phase_t phase;
		logic [31:0] start_cnt;
		logic startup_done;
		logic above;
		logic [31:0] stamp;
		logic [31:0] last_cross;
		logic [11:0] pre_cnt;
		logic [8:0] unit_cnt;
		logic [7:0] period;
		logic [6:0] avg;
		logic [22:0] acc;
		logic [15:0] nsamp;
		logic div_busy;
		logic [4:0] div_idx;
		logic [22:0] div_num;
		logic [15:0] div_den;
		logic [16:0] div_rem;
		logic [22:0] div_quo;
		logic [31:0] zc_stamp;
		logic zc_pulse;
		logic half_tick;
		logic [15:0] freq_10hz;
	} pfl_state_t;

endpackage

/* rtl/pfl_line_detect.sv */
// Purpose: Switching frequency selection, power-on source selection and
//          ac line period / zero crossing measurement of a PFC controller.
// Assumes: Line sense samples arrive on mclk with a one-cycle valid strobe;
//          the power-on request pin is asynchronous.
// Notes:   Period LSB is 100 us; half_cycle_tick paces line-cycle sequencing.
`timescale 1ns/1ps
`include "pfl_consts.svh"

module pfl_line_detect
#(
	parameter int unsigned STARTUP_CYCLES = `PFL_STARTUP_TIME_MS * 1000000 / `PFL_MCLK_PERIOD_NS
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic power_on_request,
	input wire logic [6:0] rectified_line_sense,
	input wire logic sense_valid,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic converter_on,
	output logic [15:0] switching_freq_10hz,
	output logic [7:0] line_period,
	output logic [6:0] line_average,
	output logic half_cycle_tick,
	output logic zero_cross_pulse,
	output logic [31:0] zero_cross_stamp
);

	localparam logic [11:0] LSB_CYCLES = 12'(`PFL_PERIOD_LSB_CYCLES);

	// Frequency in 10 Hz units, indexed by the six-bit code
	localparam logic [15:0] FREQ_TABLE [64] = '{
		16'd3005, 16'd3255, 16'd3551, 16'd3906, 16'd4340, 16'd4883, 16'd5206, 16'd5580,
		16'd6010, 16'd6510, 16'd7102, 16'd7813, 16'd8681, 16'd9766, 16'd10081, 16'd10417,
		16'd10776, 16'd11161, 16'd11574, 16'd12019, 16'd12500, 16'd13021, 16'd13587, 16'd14205,
		16'd14881, 16'd15625, 16'd16447, 16'd17361, 16'd18382, 16'd19531, 16'd19841, 16'd20161,
		16'd20492, 16'd20833, 16'd21186, 16'd21552, 16'd21930, 16'd22321, 16'd22727, 16'd23148,
		16'd23585, 16'd24038, 16'd24510, 16'd25000, 16'd25510, 16'd26042, 16'd26596, 16'd27174,
		16'd27778, 16'd28409, 16'd29070, 16'd29762, 16'd30488, 16'd31250, 16'd32051, 16'd32895,
		16'd33784, 16'd34722, 16'd35714, 16'd36765, 16'd37879, 16'd39063, 16'd40323, 16'd40323
	};

	pfl_pkg::pfl_state_t r_reg;
	pfl_pkg::pfl_state_t r_next;

	always_comb
	begin
		logic pin_active;
		logic [6:0] thr;
		logic falling;
		logic timeout;
		logic end_interval;
		logic [31:0] interval;
		logic [16:0] trial;
		pin_active = 1'b0;
		thr = 7'h00;
		falling = 1'b0;
		timeout = 1'b0;
		end_interval = 1'b0;
		interval = 32'h0;
		trial = 17'h0;
		r_next = r_reg;
		r_next.zc_pulse = 1'b0;
		r_next.half_tick = 1'b0;
		// Two flops on the asynchronous power-on pin; only pin_s2 feeds logic
		r_next.pin_s1 = power_on_request;
		r_next.pin_s2 = r_reg.pin_s1;
		// Stamp wraps freely; modulo subtraction keeps intervals right across a wrap
		r_next.stamp = r_reg.stamp + 32'h1;
		r_next.freq_10hz = FREQ_TABLE[r_reg.freq_sel[5:0]];

		// Read-only and unmapped offsets fall to default, so writes there are dropped
		if (reg_wr)
		begin
			case (reg_addr)
				`PFL_ADDR_BUS_POWER_CMD: r_next.bus_cmd = reg_wdata;
				`PFL_ADDR_POWER_SRC: r_next.src_cfg = reg_wdata;
				`PFL_ADDR_FREQ_SEL: r_next.freq_sel = reg_wdata;
				`PFL_ADDR_LEVEL_CFG: r_next.level_cfg = reg_wdata;
				`PFL_ADDR_PERIOD_FLOOR: r_next.floor_cfg = reg_wdata;
				`PFL_ADDR_PERIOD_CEIL: r_next.ceil_cfg = reg_wdata;
				default: r_next.bus_cmd = r_reg.bus_cmd;
			endcase
		end
		// Read data is registered and holds until the next read strobe
		if (reg_rd)
		begin
			case (reg_addr)
				`PFL_ADDR_BUS_POWER_CMD: r_next.rdata = r_reg.bus_cmd;
				`PFL_ADDR_POWER_SRC: r_next.rdata = r_reg.src_cfg;
				`PFL_ADDR_FREQ_SEL: r_next.rdata = r_reg.freq_sel;
				`PFL_ADDR_LEVEL_CFG: r_next.rdata = r_reg.level_cfg;
				`PFL_ADDR_AVG_READ: r_next.rdata = {1'b0, r_reg.avg};
				`PFL_ADDR_PERIOD_FLOOR: r_next.rdata = r_reg.floor_cfg;
				`PFL_ADDR_PERIOD_CEIL: r_next.rdata = r_reg.ceil_cfg;
				`PFL_ADDR_PERIOD_READ: r_next.rdata = r_reg.period;
				default: r_next.rdata = 8'h00;
			endcase
		end

		// Polarity bit set means the pin is active high
		pin_active = (r_reg.pin_s2 == r_reg.src_cfg[`PFL_SRC_POL_BIT]);
		r_next.conv_on = (r_reg.src_cfg[`PFL_SRC_PIN_EN_BIT] & pin_active)
			| (r_reg.src_cfg[`PFL_SRC_CMD_EN_BIT] & r_reg.bus_cmd[`PFL_CMD_ON_BIT]);

		if (!r_reg.conv_on)
		begin
			// Nothing is measured until power-on is requested
			r_next.phase = pfl_pkg::PFL_IDLE;
			r_next.start_cnt = 32'h0;
			r_next.startup_done = 1'b0;
			r_next.above = 1'b0;
			r_next.pre_cnt = 12'h0;
			r_next.unit_cnt = 9'h0;
			r_next.acc = 23'h0;
			r_next.nsamp = 16'h0;
		end
		else
		begin
			if (r_reg.start_cnt == STARTUP_CYCLES)
			begin
				r_next.startup_done = 1'b1;
			end
			else
			begin
				r_next.start_cnt = r_reg.start_cnt + 32'h1;
			end
			if (r_reg.pre_cnt == LSB_CYCLES - 12'h1)
			begin
				r_next.pre_cnt = 12'h0;
				// Saturate so a long dead line cannot wrap into a valid-looking period
				if (r_reg.unit_cnt != 9'h1ff)
				begin
					r_next.unit_cnt = r_reg.unit_cnt + 9'h1;
				end
			end
			else
			begin
				r_next.pre_cnt = r_reg.pre_cnt + 12'h1;
			end

			// Fixed threshold while starting, half-period average after
			thr = r_reg.startup_done ? r_reg.avg : r_reg.level_cfg[6:0];
			if (sense_valid)
			begin
				falling = r_reg.above && (rectified_line_sense < thr);
				r_next.above = (rectified_line_sense >= thr);
				if (r_reg.acc <= 23'h7fffff - 23'h7f && r_reg.nsamp != 16'hffff)
				begin
					r_next.acc = r_reg.acc + {16'h0, rectified_line_sense};
					r_next.nsamp = r_reg.nsamp + 16'h1;
				end
			end
			// Strictly above the ceiling, so a period equal to the ceiling still counts
			timeout = (r_reg.unit_cnt > {1'b0, r_reg.ceil_cfg});
			unique case (r_reg.phase)
				pfl_pkg::PFL_IDLE:
				begin
					r_next.phase = pfl_pkg::PFL_ARM;
					r_next.pre_cnt = 12'h0;
					r_next.unit_cnt = 9'h0;
				end
				pfl_pkg::PFL_ARM:
				begin
					if (falling)
					begin
						r_next.phase = pfl_pkg::PFL_MEAS;
						r_next.last_cross = r_reg.stamp;
						end_interval = 1'b1;
					end
					else if (timeout)
					begin
						r_next.period = r_reg.ceil_cfg;
						r_next.half_tick = 1'b1;
						end_interval = 1'b1;
					end
				end
				pfl_pkg::PFL_MEAS:
				begin
					if (falling)
					begin
						if (r_reg.unit_cnt > {1'b0, r_reg.ceil_cfg}
							|| r_reg.unit_cnt < {1'b0, r_reg.floor_cfg})
						begin
							r_next.period = r_reg.ceil_cfg;
						end
						else
						begin
							r_next.period = r_reg.unit_cnt[7:0];
						end
						interval = r_reg.stamp - r_reg.last_cross;
						r_next.zc_stamp = r_reg.stamp - {1'b0, interval[31:1]};
						r_next.zc_pulse = 1'b1;
						r_next.half_tick = 1'b1;
						r_next.last_cross = r_reg.stamp;
						end_interval = 1'b1;
					end
					else if (timeout)
					begin
						// Lost line: fall back to ceiling and hunt again
						r_next.period = r_reg.ceil_cfg;
						r_next.half_tick = 1'b1;
						r_next.phase = pfl_pkg::PFL_ARM;
						end_interval = 1'b1;
					end
				end
				default: r_next.phase = pfl_pkg::PFL_IDLE;
			endcase
			if (end_interval)
			begin
				r_next.pre_cnt = 12'h0;
				r_next.unit_cnt = 9'h0;
				// The crossing sample opens the new half period, so no sample is lost
				r_next.acc = sense_valid ? {16'h0, rectified_line_sense} : 23'h0;
				r_next.nsamp = sense_valid ? 16'h1 : 16'h0;
				// A division still running is abandoned for the newer half period only when the half period just ended holds samples
				if (r_reg.nsamp != 16'h0)
				begin
					r_next.div_busy = 1'b1;
					r_next.div_idx = 5'd22;
					r_next.div_num = r_reg.acc;
					r_next.div_den = r_reg.nsamp;
					r_next.div_rem = 17'h0;
					r_next.div_quo = 23'h0;
				end
			end
		end

		// Bit-serial divide keeps the average cheap; result lands 23 cycles later
		if (r_reg.div_busy && !(r_reg.conv_on && end_interval))
		begin
			trial = {r_reg.div_rem[15:0], r_reg.div_num[r_reg.div_idx]};
			r_next.div_quo = r_reg.div_quo;
			if (trial >= {1'b0, r_reg.div_den})
			begin
				r_next.div_rem = trial - {1'b0, r_reg.div_den};
				r_next.div_quo[r_reg.div_idx] = 1'b1;
			end
			else
			begin
				r_next.div_rem = trial;
			end
			if (r_reg.div_idx == 5'd0)
			begin
				r_next.div_busy = 1'b0;
				r_next.avg = (r_next.div_quo > 23'h7f) ? 7'h7f : r_next.div_quo[6:0];
			end
			else
			begin
				r_next.div_idx = r_reg.div_idx - 5'd1;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			r_reg <= '0;
			r_reg.bus_cmd <= `PFL_RST_BUS_POWER_CMD;
			r_reg.src_cfg <= `PFL_RST_POWER_SRC;
			r_reg.freq_sel <= `PFL_RST_FREQ_SEL;
			r_reg.level_cfg <= `PFL_RST_LEVEL_CFG;
			r_reg.floor_cfg <= `PFL_RST_PERIOD_FLOOR;
			r_reg.ceil_cfg <= `PFL_RST_PERIOD_CEIL;
			// Readers see the ceiling fallback before any measurement completes
			r_reg.period <= `PFL_RST_PERIOD_CEIL;
			r_reg.phase <= pfl_pkg::PFL_IDLE;
		end
		else
		begin
			r_reg <= r_next;
		end
	end

	assign reg_rdata = r_reg.rdata;
	assign converter_on = r_reg.conv_on;
	assign switching_freq_10hz = r_reg.freq_10hz;
	assign line_period = r_reg.period;
	assign line_average = r_reg.avg;
	assign half_cycle_tick = r_reg.half_tick;
	assign zero_cross_pulse = r_reg.zc_pulse;
	assign zero_cross_stamp = r_reg.zc_stamp;

endmodule

/* testbench/pfl_line_monitor.sv */
// Purpose: Port checker for pfl_line_detect.
// Assumes: Config registers change only through reg_wr.
// Notes: Shadows the few config registers the properties need.
`timescale 1ns/1ps
`include "pfl_consts.svh"
module pfl_line_monitor
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic power_on_request,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic converter_on,
	input wire logic [15:0] switching_freq_10hz,
	input wire logic [7:0] line_period,
	input wire logic [6:0] line_average,
	input wire logic half_cycle_tick,
	input wire logic zero_cross_pulse,
	input wire logic [31:0] zero_cross_stamp
);
	logic [7:0] src_reg, cmd_reg, floor_reg, ceil_reg;
	logic exp_on;
	assign exp_on = (src_reg[3] && power_on_request == src_reg[1]) || (src_reg[2] && cmd_reg[7]);
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			src_reg <= `PFL_RST_POWER_SRC;
			cmd_reg <= `PFL_RST_BUS_POWER_CMD;
			floor_reg <= `PFL_RST_PERIOD_FLOOR;
			ceil_reg <= `PFL_RST_PERIOD_CEIL;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`PFL_ADDR_POWER_SRC: src_reg <= reg_wdata;
				`PFL_ADDR_BUS_POWER_CMD: cmd_reg <= reg_wdata;
				`PFL_ADDR_PERIOD_FLOOR: floor_reg <= reg_wdata;
				`PFL_ADDR_PERIOD_CEIL: ceil_reg <= reg_wdata;
				default: ;
			endcase
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_freq_end;
		reg_wr && reg_addr == `PFL_ADDR_FREQ_SEL && (reg_wdata[5:0] == 0 || reg_wdata[5:0] >= 62);
	endsequence
	// Six quiet cycles cover the two-flop synchroniser plus evaluation
	sequence s_src_quiet;
		($stable(power_on_request) && $stable(exp_on))[*6];
	endsequence
	property p_freq; s_freq_end |=> ##1
		switching_freq_10hz == ($past(reg_wdata[5:0], 2) == 6'h00 ? 16'd3005 : 16'd40323);
	endproperty
	a_freq: assert property (p_freq) else $error("frequency code mismatch");
	property p_src; s_src_quiet |-> converter_on == exp_on; endproperty
	a_src: assert property (p_src) else $error("power-on source mismatch");
	property p_zc_tick; zero_cross_pulse |-> half_cycle_tick; endproperty
	a_zc_tick: assert property (p_zc_tick) else $error("crossing without tick");
	property p_period_upd; $changed(line_period) |-> half_cycle_tick; endproperty
	a_period_upd: assert property (p_period_upd) else $error("period moved off tick");
	property p_rd_period; reg_rd && reg_addr == `PFL_ADDR_PERIOD_READ |=>
		reg_rdata == $past(line_period); endproperty
	a_rd_period: assert property (p_rd_period) else $error("period read mismatch");
	property p_rd_avg; reg_rd && reg_addr == `PFL_ADDR_AVG_READ |=>
		reg_rdata == {1'b0, $past(line_average)}; endproperty
	a_rd_avg: assert property (p_rd_avg) else $error("average read mismatch");
	property p_limit; half_cycle_tick |-> line_period == ceil_reg ||
		(line_period >= floor_reg && line_period <= ceil_reg); endproperty
	a_limit: assert property (p_limit) else $error("period outside limits");
	property p_stamp; $changed(zero_cross_stamp) |-> zero_cross_pulse; endproperty
	a_stamp: assert property (p_stamp) else $error("stamp moved off pulse");
	property p_gate; half_cycle_tick |-> $past(converter_on); endproperty
	a_gate: assert property (p_gate) else $error("tick while off");
endmodule
bind pfl_line_detect pfl_line_monitor u_mon (.mclk(mclk), .rst(rst),
	.power_on_request(power_on_request), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .converter_on(converter_on),
	.switching_freq_10hz(switching_freq_10hz), .line_period(line_period),
	.line_average(line_average), .half_cycle_tick(half_cycle_tick),
	.zero_cross_pulse(zero_cross_pulse), .zero_cross_stamp(zero_cross_stamp));

/* testbench/pfl_line_model.sv */
// Purpose: Rectified line sense source, one sample per 100 cycles.
// Assumes: HALF is a multiple of 100, so crossings are exactly HALF apart.
// Notes: High half then low half gives one falling crossing per period.
`timescale 1ns/1ps
module pfl_line_model
#(
	parameter int HALF = 8100
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic en,
	output logic [6:0] sense,
	output logic valid
);
	int cnt;
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cnt <= 0;
			valid <= 1'b0;
			sense <= 7'h00;
		end
		else if (en)
		begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			valid <= (cnt % 100) == 0;
			sense <= (cnt < HALF / 2) ? 7'h60 : 7'h08;
		end
		else
		begin
			// Idle line: no samples, value keeps moving so nothing stale looks valid
			valid <= 1'b0;
			sense <= ~sense;
		end
	end
endmodule

/* testbench/tb.sv */
// Purpose: Register and line-measurement scenarios for pfl_line_detect.
// Assumes: Period unit is 4000 cycles; startup shortened to 20000 cycles.
// Notes: Limits are lowered so periods fit a short run.
`timescale 1ns/1ps
`include "pfl_consts.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
	$display("unexpected %0t: got %h exp %h", $time, a, e); end end
module tb;
	localparam int HALF = 8100;
	logic mclk, rst, pin, en, valid, reg_wr, reg_rd, on, tick, zcp;
	logic [6:0] sense, avg;
	logic [15:0] reg_addr, freq;
	logic [7:0] reg_wdata, rdata, period;
	logic [31:0] zcs, cyc, s1, w, k;
	int n_mismatch, n_compared;
	logic [15:0] ra[9] = '{16'h0001, 16'h0002, 16'hfe1b, 16'hfe25, 16'hfe26, 16'hfe27, 16'hfe28,
		16'hfe85, 16'h1234};
	logic [7:0] rv[9] = '{8'h00, 8'h0a, 8'h00, 8'h20, 8'h00, 8'h46, 8'h6e, 8'h6e, 8'h00};
	logic [5:0] fc[5] = '{6'd0, 6'd1, 6'd20, 6'd62, 6'd63};
	logic [15:0] fv[5] = '{16'd3005, 16'd3255, 16'd12500, 16'd40323, 16'd40323};
	pfl_line_detect #(.STARTUP_CYCLES(20000)) uut (.mclk(mclk), .rst(rst), .power_on_request(pin),
		.rectified_line_sense(sense), .sense_valid(valid), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
		.converter_on(on), .switching_freq_10hz(freq), .line_period(period),
		.line_average(avg), .half_cycle_tick(tick), .zero_cross_pulse(zcp),
		.zero_cross_stamp(zcs));
	pfl_line_model #(.HALF(HALF)) u_line (.mclk(mclk), .rst(rst), .en(en), .sense(sense),
		.valid(valid));
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) cyc <= rst ? 32'h0 : cyc + 1;
	task results;
		if (n_mismatch == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step(1);
		reg_wr = 1'b0;
		step(1);
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1'b1;
		step(1);
		reg_rd = 1'b0;
		step(1);
		`CHK(rdata, e)
	endtask
	task pwr(input logic [7:0] src, input logic [7:0] cmd, input logic p, input logic e);
		wr(`PFL_ADDR_POWER_SRC, src);
		wr(`PFL_ADDR_BUS_POWER_CMD, cmd);
		pin = p;
		step(6);
		`CHK(on, e)
	endtask
	// Bounded wait for a crossing pulse (zc=1) or any half-cycle tick
	task wait_ev(input bit zc, input int lim);
		w = 0;
		do
		begin
			step(1);
			w++;
		end
		while (((zc ? zcp : tick) !== 1'b1) && w < lim);
		if ((zc ? zcp : tick) !== 1'b1)
		begin
			n_mismatch++;
			$display("unexpected %0t: wait ran out", $time);
			results();
		end
	endtask
	initial
	begin
		{rst, pin, en, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b110, 2'b00, 16'h0, 8'h0};
		n_mismatch = 0;
		n_compared = 0;
		repeat (4) @(posedge mclk);
		#1 rst = 1'b0;
		for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
		wr(`PFL_ADDR_PERIOD_READ, 8'h55);
		wr(`PFL_ADDR_AVG_READ, 8'h55);
		rd(`PFL_ADDR_PERIOD_READ, 8'h6e);
		rd(`PFL_ADDR_AVG_READ, 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			wr(`PFL_ADDR_FREQ_SEL, {2'b11, fc[i]});
			step(2);
			`CHK(freq, fv[i])
		end
		pwr(8'h08, 8'h00, 1'b1, 1'b0);
		pwr(8'h08, 8'h00, 1'b0, 1'b1);
		pwr(8'h04, 8'h80, 1'b0, 1'b1);
		pwr(8'h0e, 8'h00, 1'b1, 1'b1);
		pwr(8'h04, 8'h00, 1'b1, 1'b0);
		en = 1'b1;
		k = 0;
		repeat (2 * HALF)
		begin
			step(1);
			k += tick;
		end
		`CHK(k, 32'h0)
		wr(`PFL_ADDR_PERIOD_FLOOR, 8'h01);
		wr(`PFL_ADDR_PERIOD_CEIL, 8'h03);
		pwr(8'h0a, 8'h00, 1'b1, 1'b1);
		wait_ev(1'b1, 2 * HALF + 500);
		`CHK(period, 8'h02)
		s1 = zcs;
		wait_ev(1'b1, HALF + 50);
		`CHK(zcs - s1, HALF)
		`CHK((cyc - zcs) inside {[HALF / 2 - 1 : HALF / 2 + 3]}, 1'b1)
		wr(`PFL_ADDR_PERIOD_FLOOR, 8'h03);
		wait_ev(1'b1, HALF + 50);
		`CHK(period, 8'h03)
		step(30);
		`CHK(avg, 7'h34)
		rd(`PFL_ADDR_AVG_READ, 8'h34);
		wr(`PFL_ADDR_PERIOD_FLOOR, 8'h01);
		wait_ev(1'b1, HALF + 50);
		`CHK(period, 8'h02)
		en = 1'b0;
		wait_ev(1'b0, 17000);
		`CHK({period, zcp, w >= 12000 && w <= 16100}, {8'h03, 2'b01})
		results();
	end
endmodule
